// file: hw/acq_pkg.sv
// Constants shared by the acquisition sequencer and its helpers.
// Assumes a single 20 MHz clock and a classic Wishbone register slave.
package acq_pkg;
    // Clock and timing
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned TIMEBASE_HZ = 10000000;
    localparam int unsigned TB_DIV = CLK_HZ / TIMEBASE_HZ;
    localparam int unsigned CONV_TIME_NS = 500;
    localparam int unsigned CONV_CYC = (CONV_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
    // Register word offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] PACE_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] DATA_OFS = 8'h0c;
    localparam logic [7:0] NCNT_OFS = 8'h10;
    localparam logic [7:0] MCNT_OFS = 8'h14;
    localparam logic [7:0] CMD_OFS = 8'h18;
    localparam logic [7:0] CHAN_OFS = 8'h40;
    // Control field positions
    localparam int unsigned MODE_LSB = 0;
    localparam int unsigned CLKSEL_BIT = 3;
    localparam int unsigned TRGSRC_LSB = 4;
    localparam int unsigned TRGEDGE_BIT = 6;
    localparam int unsigned DMAEN_BIT = 7;
    // Command bits
    localparam int unsigned CMD_START_BIT = 0;
    localparam int unsigned CMD_STOP_BIT = 1;
    localparam int unsigned CMD_SWTRG_BIT = 2;
    // Status bit positions
    localparam int unsigned ST_EMPTY_BIT = 0;
    localparam int unsigned ST_RUN_BIT = 1;
    localparam int unsigned ST_ARMED_BIT = 2;
    localparam int unsigned ST_BUSY_BIT = 3;
    // Reset values, channel count and FIFO depth
    localparam logic [15:0] PACE_RST = 16'h0010;
    localparam logic [15:0] MCNT_MIN = 16'h0002;
    localparam logic [11:0] MIDSCALE = 12'h800;
    localparam int unsigned NCHAN = 16;
    localparam int unsigned FIFO_DEPTH = 16;
    // Gain codes
    localparam logic [2:0] GAIN_HALF = 3'h0;
    localparam logic [2:0] GAIN_MAX = 3'h4;

    typedef enum logic [2:0]
    {
        MODE_SINGLE,
        MODE_PACER,
        MODE_POST,
        MODE_DELAY,
        MODE_ABOUT,
        MODE_PRE
    } acq_mode_t;

    typedef enum logic [1:0]
    {
        TRG_SOFT,
        TRG_DIGITAL,
        TRG_ANALOG
    } trg_src_t;
endpackage : acq_pkg

// file: hw/acq_pacer.sv
// Internal pacing counter on a 10 MHz enable derived from the system clock.
// Assumes the divisor register is stable while pacing runs.
`timescale 1ns/10ps
`default_nettype none
module acq_pacer
(
    input wire logic mclk_i, // System clock
    input wire logic rst_n_i, // Async reset, active low
    input wire logic run_i, // Pacing enabled
    input wire logic [15:0] divisor_i, // Time base ticks per sample
    output logic tick_o // One-cycle rising edge of pacing output
);
    logic [3:0] pre_r;
    logic [15:0] cnt_r;
    logic tb_en;
    logic wrap;

    assign tb_en = (pre_r == 4'(acq_pkg::TB_DIV - 1));
    assign wrap = (cnt_r <= 16'h0001);

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pre_r <= 4'h0;
            cnt_r <= 16'h0000;
            tick_o <= 1'b0;
        end
        else
        begin
            pre_r <= (!run_i || tb_en) ? 4'h0 : pre_r + 4'h1;
            tick_o <= run_i && tb_en && wrap;
            if (!run_i)
                cnt_r <= divisor_i;
            else if (tb_en)
                cnt_r <= wrap ? divisor_i : cnt_r - 16'h0001;
        end
    end
endmodule : acq_pacer
`default_nettype wire

// file: hw/acq_fifo.sv
// Small result FIFO in flip-flops; data output is the head entry, not registered.
// Pushes while full are dropped; the writer does not check full.
`timescale 1ns/10ps
`default_nettype none
module acq_fifo
(
    input wire logic mclk_i, // System clock
    input wire logic rst_n_i, // Async reset, active low
    input wire logic push_i, // Write one sample
    input wire logic [11:0] wdata_i, // Sample to write
    input wire logic pop_i, // Remove head sample
    output logic [11:0] rdata_o, // Head sample
    output logic empty_o, // No data
    output logic full_o // No room
);
    localparam int unsigned AW = $clog2(acq_pkg::FIFO_DEPTH);
    logic [11:0] mem_r [acq_pkg::FIFO_DEPTH];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    logic do_push;
    logic do_pop;

    assign empty_o = (wp_r == rp_r);
    assign full_o = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
    assign do_push = push_i && !full_o;
    assign do_pop = pop_i && !empty_o;
    assign rdata_o = mem_r[rp_r[AW-1:0]];

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wp_r <= '0;
            rp_r <= '0;
        end
        else
        begin
            if (do_push)
                wp_r <= wp_r + 1'b1;
            if (do_pop)
                rp_r <= rp_r + 1'b1;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (do_push)
            mem_r[wp_r[AW-1:0]] <= wdata_i;
    end
endmodule : acq_fifo
`default_nettype wire

// file: hw/acq_seq.sv
// Analog input acquisition sequencer with Wishbone registers.
// Assumes converter, clock and trigger pins are synchronous to mclk_i.
// Operation
// - Six mode codes, software picks one per run; about and pre never leave idle.
// - Single mode: each software trigger not landing mid-conversion makes one conversion, result stored at once.
// - Status word at offset 8 shows FIFO empty.
// - Pacer clock from internal counter or external pin, software selects.
// - Pacer converts on every clock from the first except those landing mid-conversion, with no stop count.
// - Clocked-mode results go into the FIFO in conversion order.
// - Post-trigger starts on trigger, stops at count N or software stop.
// - Delay mode waits M clocks (2..65535) after trigger before storing.
// - Delay mode armed by start command, ends at N samples or stop.
// - Per-channel polarity and gain; gain 0.5 only bipolar.
// - Internal pacing from 10 MHz base, conversion on counter rising edge.
// - External clock conversion on rising edge, up to 2 MHz.
// - Software, digital or analog trigger with selectable edge.
`timescale 1ns/10ps
`default_nettype none
module acq_seq
(
    input wire logic mclk_i, // 20 MHz clock
    input wire logic rst_n_i, // Async reset, active low
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [7:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte selects
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    input wire logic external_sample_clock_pin_i, // External sample clock
    input wire logic external_digital_trigger_pin_i, // Digital trigger
    input wire logic analog_threshold_trigger_pin_i, // Comparator output
    output logic adc_start_o, // Conversion start pulse
    input wire logic adc_done_i, // Conversion finished pulse
    input wire logic [11:0] adc_data_i, // Straight binary result
    output logic [3:0] adc_chan_o, // Channel being converted
    output logic adc_bipolar_o, // Polarity for that channel
    output logic [2:0] adc_gain_o // Gain code for that channel
);
    ////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0]
    {
        ST_IDLE,
        ST_ARM,
        ST_DELAY,
        ST_RUN
    } seq_state_t;

    seq_state_t state_r;
    logic [7:0] ctrl_r;
    logic [15:0] pace_r;
    logic [15:0] ncnt_r;
    logic [15:0] mcnt_r;
    logic [15:0] left_r;
    logic [15:0] dly_r;
    logic [3:0] chan_r [acq_pkg::NCHAN];
    logic busy_r;
    logic store_r;
    logic ext_q_r;
    logic dig_q_r;
    logic ana_q_r;
    logic swtrg_q_r;
    logic swtrg_lvl_r;
    logic ack_r;
    logic [31:0] rd_r;

    ////////////////////////////////////////////////////////////////////
    // Bus decode
    logic wb_req;
    logic wr;
    logic rd;
    logic hit_ctrl;
    logic hit_pace;
    logic hit_ncnt;
    logic hit_mcnt;
    logic hit_cmd;
    logic hit_data;
    logic hit_chan;
    logic [3:0] chan_idx;
    logic start_cmd;
    logic stop_cmd;
    logic swtrg_cmd;

    assign wb_req = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr = wb_req && wb_we_i;
    assign rd = wb_req && !wb_we_i;
    assign hit_ctrl = (wb_adr_i == acq_pkg::CTRL_OFS);
    assign hit_pace = (wb_adr_i == acq_pkg::PACE_OFS);
    assign hit_ncnt = (wb_adr_i == acq_pkg::NCNT_OFS);
    assign hit_mcnt = (wb_adr_i == acq_pkg::MCNT_OFS);
    assign hit_cmd = (wb_adr_i == acq_pkg::CMD_OFS);
    assign hit_data = (wb_adr_i == acq_pkg::DATA_OFS);
    assign hit_chan = (wb_adr_i[7:6] == acq_pkg::CHAN_OFS[7:6]) && (wb_adr_i[1:0] == 2'b00);
    assign chan_idx = wb_adr_i[5:2];
    assign start_cmd = wr && hit_cmd && wb_sel_i[0] && wb_dat_i[acq_pkg::CMD_START_BIT];
    assign stop_cmd = wr && hit_cmd && wb_sel_i[0] && wb_dat_i[acq_pkg::CMD_STOP_BIT];
    assign swtrg_cmd = wr && hit_cmd && wb_sel_i[0] && wb_dat_i[acq_pkg::CMD_SWTRG_BIT];

    ////////////////////////////////////////////////////////////////////
    // Control fields
    acq_pkg::acq_mode_t mode;
    acq_pkg::trg_src_t trg_src;
    logic clk_ext;
    logic edge_fall;

    assign mode = acq_pkg::acq_mode_t'(ctrl_r[acq_pkg::MODE_LSB +: 3]);
    assign trg_src = acq_pkg::trg_src_t'(ctrl_r[acq_pkg::TRGSRC_LSB +: 2]);
    assign clk_ext = ctrl_r[acq_pkg::CLKSEL_BIT];
    assign edge_fall = ctrl_r[acq_pkg::TRGEDGE_BIT];

    ////////////////////////////////////////////////////////////////////
    // Sample clock and trigger edges
    logic pace_tick;
    logic ext_rise;
    logic sample_clk;
    logic trg_lvl;
    logic trg_prev;
    logic trg_edge;
    logic clocked;

    assign clocked = (state_r != ST_IDLE);

    acq_pacer u_pacer
    (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .run_i(clocked && !clk_ext),
        .divisor_i(pace_r),
        .tick_o(pace_tick)
    );

    assign ext_rise = external_sample_clock_pin_i && !ext_q_r;
    assign sample_clk = clk_ext ? ext_rise : pace_tick;

    always_comb
    begin
        unique case (trg_src)
            acq_pkg::TRG_DIGITAL:
            begin
                trg_lvl = external_digital_trigger_pin_i;
                trg_prev = dig_q_r;
            end
            acq_pkg::TRG_ANALOG:
            begin
                trg_lvl = analog_threshold_trigger_pin_i;
                trg_prev = ana_q_r;
            end
            default:
            begin
                trg_lvl = swtrg_lvl_r;
                trg_prev = swtrg_q_r;
            end
        endcase
    end

    // Chosen edge of the chosen source
    assign trg_edge = edge_fall ? (trg_prev && !trg_lvl) : (!trg_prev && trg_lvl);

    ////////////////////////////////////////////////////////////////////
    // Sequencer
    logic conv_go;
    logic single_go;
    logic fifo_full;
    logic fifo_empty;
    logic [11:0] fifo_q;
    logic fifo_pop;

    // Overlapping clocks while busy are dropped
    assign conv_go = (state_r == ST_RUN) && sample_clk && !busy_r && !stop_cmd;
    assign single_go = (mode == acq_pkg::MODE_SINGLE) && swtrg_cmd && !busy_r;
    assign fifo_pop = rd && hit_data && !fifo_empty;

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_r <= ST_IDLE;
            left_r <= 16'h0000;
            dly_r <= 16'h0000;
            busy_r <= 1'b0;
            store_r <= 1'b0;
        end
        else
        begin
            if (stop_cmd)
                state_r <= ST_IDLE;
            else
            begin
                unique case (state_r)
                    ST_IDLE:
                    begin
                        if (start_cmd && mode == acq_pkg::MODE_PACER)
                            state_r <= ST_RUN;
                        else if (start_cmd && (mode == acq_pkg::MODE_POST
                                 || mode == acq_pkg::MODE_DELAY))
                            state_r <= ST_ARM;
                        left_r <= ncnt_r;
                        dly_r <= (mcnt_r < acq_pkg::MCNT_MIN) ? acq_pkg::MCNT_MIN : mcnt_r;
                    end
                    ST_ARM:
                    begin
                        if (trg_edge)
                            state_r <= (mode == acq_pkg::MODE_DELAY) ? ST_DELAY : ST_RUN;
                    end
                    ST_DELAY:
                    begin
                        if (sample_clk)
                        begin
                            dly_r <= dly_r - 16'h0001;
                            if (dly_r == 16'h0001)
                                state_r <= ST_RUN;
                        end
                    end
                    ST_RUN:
                    begin
                        if (conv_go && mode != acq_pkg::MODE_PACER)
                        begin
                            left_r <= left_r - 16'h0001;
                            if (left_r <= 16'h0001)
                                state_r <= ST_IDLE;
                        end
                    end
                endcase
            end
            if (conv_go || single_go)
                busy_r <= 1'b1;
            else if (adc_done_i)
                busy_r <= 1'b0;
            if (conv_go || single_go)
                store_r <= 1'b1;
            else if (adc_done_i)
                store_r <= 1'b0;
        end
    end

    assign adc_start_o = conv_go || single_go;

    acq_fifo u_fifo
    (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .push_i(adc_done_i && store_r),
        .wdata_i(adc_data_i),
        .pop_i(fifo_pop),
        .rdata_o(fifo_q),
        .empty_o(fifo_empty),
        .full_o(fifo_full)
    );

    ////////////////////////////////////////////////////////////////////
    // Channel settings and pin samples
    logic [3:0] cur_chan;
    assign cur_chan = 4'h0;
    assign adc_chan_o = cur_chan;
    assign adc_bipolar_o = chan_r[cur_chan][3];
    assign adc_gain_o = chan_r[cur_chan][2:0];

    genvar gi;
    generate
        for (gi = 0; gi < acq_pkg::NCHAN; gi++)
        begin : g_chan
            always_ff @(posedge mclk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                    chan_r[gi] <= 4'h9;
                else if (wr && hit_chan && wb_sel_i[0] && chan_idx == gi
                         && wb_dat_i[2:0] <= acq_pkg::GAIN_MAX
                         && (wb_dat_i[3] || wb_dat_i[2:0] != acq_pkg::GAIN_HALF))
                    chan_r[gi] <= wb_dat_i[3:0];
            end
        end
    endgenerate

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ext_q_r <= 1'b0;
            dig_q_r <= 1'b0;
            ana_q_r <= 1'b0;
            swtrg_q_r <= 1'b0;
            swtrg_lvl_r <= 1'b0;
        end
        else
        begin
            ext_q_r <= external_sample_clock_pin_i;
            dig_q_r <= external_digital_trigger_pin_i;
            ana_q_r <= analog_threshold_trigger_pin_i;
            swtrg_q_r <= swtrg_lvl_r;
            if (swtrg_cmd)
                swtrg_lvl_r <= !edge_fall;
            else
                swtrg_lvl_r <= edge_fall;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register file
    logic hit_stat_w;
    assign hit_stat_w = (wb_adr_i == acq_pkg::STAT_OFS);
    logic [31:0] rd_mux;
    logic [31:0] status;

    assign status = {28'h0000000, busy_r, (state_r == ST_ARM), (state_r != ST_IDLE),
                     fifo_empty};

    always_comb
    begin
        rd_mux = 32'h00000000;
        if (hit_ctrl)
            rd_mux = {24'h000000, ctrl_r};
        else if (hit_pace)
            rd_mux = {16'h0000, pace_r};
        else if (hit_stat_w)
            rd_mux = status;
        else if (hit_data)
            rd_mux = {20'h00000, fifo_q};
        else if (hit_ncnt)
            rd_mux = {16'h0000, ncnt_r};
        else if (hit_mcnt)
            rd_mux = {16'h0000, mcnt_r};
        else if (hit_chan)
            rd_mux = {28'h0000000, chan_r[chan_idx]};
    end


    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ctrl_r <= 8'h00;
            pace_r <= acq_pkg::PACE_RST;
            ncnt_r <= 16'h0000;
            mcnt_r <= acq_pkg::MCNT_MIN;
            ack_r <= 1'b0;
            rd_r <= 32'h00000000;
        end
        else
        begin
            ack_r <= wb_req;
            if (rd)
                rd_r <= rd_mux;
            if (wr && hit_ctrl && wb_sel_i[0] && state_r == ST_IDLE)
                ctrl_r <= wb_dat_i[7:0];
            if (wr && hit_pace)
            begin
                if (wb_sel_i[0])
                    pace_r[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    pace_r[15:8] <= wb_dat_i[15:8];
            end
            if (wr && hit_ncnt)
            begin
                if (wb_sel_i[0])
                    ncnt_r[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    ncnt_r[15:8] <= wb_dat_i[15:8];
            end
            if (wr && hit_mcnt)
            begin
                if (wb_sel_i[0])
                    mcnt_r[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    mcnt_r[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rd_r;
endmodule : acq_seq
`default_nettype wire

// file: bench/adc_model.sv
// Converter model: answers each start pulse with one result after LAT cycles.
// Assumes start is a one-cycle pulse synchronous to mclk_i.
`timescale 1ns/10ps
`default_nettype none
module adc_model
#(
    parameter int LAT = 12
)
(
    input wire logic mclk_i, // System clock
    input wire logic rst_n_i, // Async reset, active low
    input wire logic adc_start_o, // Start pulse
    output logic adc_done_i, // Result pulse
    output logic [11:0] adc_data_i // Result code
);
    int cnt_r;
    logic [11:0] val_r;
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_r <= 0;
            adc_done_i <= 1'b0;
            adc_data_i <= 12'h000;
            val_r <= 12'h7fe;
        end
        else
        begin
            cnt_r <= adc_start_o ? LAT : (cnt_r != 0 ? cnt_r - 1 : 0);
            adc_done_i <= (cnt_r == 1);
            // Data line toggles outside the result cycle so stale values never match
            adc_data_i <= (cnt_r == 1) ? val_r : ~adc_data_i;
            if (cnt_r == 1)
                val_r <= val_r + 12'h001;
        end
    end
endmodule : adc_model
`default_nettype wire

// file: bench/acq_seq_assertions.sv
// Port-level checker for the acquisition sequencer.
// Assumes binding to acq_seq; the master holds the address until ack.
`timescale 1ns/10ps
`default_nettype none
module acq_seq_assertions
(
    input wire logic mclk_i, // Clock
    input wire logic rst_n_i, // Reset, active low
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_we_i, // Write enable
    input wire logic [7:0] wb_adr_i, // Address
    input wire logic [31:0] wb_dat_o, // Read data
    input wire logic wb_ack_o, // Acknowledge
    input wire logic adc_start_o, // Conversion start
    input wire logic adc_done_i, // Conversion done
    input wire logic adc_bipolar_o, // Polarity
    input wire logic [2:0] adc_gain_o // Gain code
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_wr;
        wb_cyc_i && wb_stb_i && wb_we_i;
    endsequence
    sequence s_rd_ack;
        wb_ack_o && !wb_we_i;
    endsequence
    property p_ack_resp;
        s_req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    property p_ack_cause;
        $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    property p_no_overlap;
        adc_start_o |=> (!adc_start_o until adc_done_i);
    endproperty
    property p_gain_max;
        adc_gain_o <= acq_pkg::GAIN_MAX;
    endproperty
    property p_half_bip;
        adc_gain_o == acq_pkg::GAIN_HALF |-> adc_bipolar_o;
    endproperty
    property p_data_fmt;
        s_rd_ack ##0 (wb_adr_i == acq_pkg::DATA_OFS) |-> wb_dat_o[31:12] == 20'h00000;
    endproperty
    property p_stat_fmt;
        s_rd_ack ##0 (wb_adr_i == acq_pkg::STAT_OFS) |-> wb_dat_o[31:4] == 28'h0000000;
    endproperty
    property p_chan_chg;
        !$stable({adc_bipolar_o, adc_gain_o}) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i)
            || $past(wb_cyc_i && wb_stb_i && wb_we_i, 2);
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("ack not a single pulse");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_no_overlap: assert property (p_no_overlap) else $error("overlapping start");
    a_gain_max: assert property (p_gain_max) else $error("gain code out of range");
    a_half_bip: assert property (p_half_bip) else $error("half gain while unipolar");
    a_data_fmt: assert property (p_data_fmt) else $error("data wider than 12 bits");
    a_stat_fmt: assert property (p_stat_fmt) else $error("status spare bits set");
    a_chan_chg: assert property (p_chan_chg) else $error("channel setting moved");
    c_seq: cover property (s_wr);
endmodule : acq_seq_assertions
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for acq_seq: Wishbone tasks, pin drivers, converter model.
// Assumes the model's result sequence starts at 7feh and counts up.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, adc_start_o, adc_done_i, adc_bipolar_o;
    logic ext_clk = 1'b0, dig_trg = 1'b0, analog_threshold_trigger_pin = 1'b1;
    logic [11:0] adc_data_i, exp_d = 12'h7fe;
    logic [3:0] adc_chan_o;
    logic [2:0] adc_gain_o;
    int n_fail = 0, n_checks = 0, cyc_cnt = 0, got;
    always #25 mclk_i = ~mclk_i;
    acq_seq uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .external_sample_clock_pin_i(ext_clk),
        .external_digital_trigger_pin_i(dig_trg), .analog_threshold_trigger_pin_i(analog_threshold_trigger_pin),
        .adc_start_o(adc_start_o), .adc_done_i(adc_done_i), .adc_data_i(adc_data_i),
        .adc_chan_o(adc_chan_o), .adc_bipolar_o(adc_bipolar_o), .adc_gain_o(adc_gain_o));
    adc_model u_adc (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .adc_start_o(adc_start_o),
        .adc_done_i(adc_done_i), .adc_data_i(adc_data_i));
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
    begin
        if (n_fail == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask : wrap_up
    always @(posedge mclk_i)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000)
        begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
    begin
        n_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("FAIL %0t got %h want %h", $time, g, e);
        end
    end
    endtask : chk
    // Classic cycle: hold everything until ack is sampled, then release
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    begin
        @(posedge mclk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        @(posedge mclk_i);
        while (wb_ack_o !== 1'b1)
            @(posedge mclk_i);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    end
    endtask : wb
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    begin
        wb(1'b0, a, 32'h0);
        chk(rd, e);
    end
    endtask : rdc
    // Gap of 40 cycles keeps the rate near 465 kS/s
    task automatic sclk(input int n, input int gap);
    begin
        repeat (n)
        begin
            @(posedge mclk_i);
            ext_clk <= 1'b1;
            repeat (2) @(posedge mclk_i);
            ext_clk <= 1'b0;
            repeat (gap) @(posedge mclk_i);
        end
    end
    endtask : sclk
    task automatic idle_wait;
    begin
        do wb(1'b0, acq_pkg::STAT_OFS, 32'h0); while (rd[3] !== 1'b0);
    end
    endtask : idle_wait
    task automatic drain;
    begin
        got = 0;
        wb(1'b0, acq_pkg::STAT_OFS, 32'h0);
        while (rd[0] === 1'b0)
        begin
            rdc(acq_pkg::DATA_OFS, {20'h0, exp_d});
            exp_d++;
            got++;
            wb(1'b0, acq_pkg::STAT_OFS, 32'h0);
        end
    end
    endtask : drain
    ////////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rdc(acq_pkg::CTRL_OFS, 32'h0);
        rdc(acq_pkg::PACE_OFS, {16'h0, acq_pkg::PACE_RST});
        rdc(acq_pkg::MCNT_OFS, {16'h0, acq_pkg::MCNT_MIN});
        rdc(acq_pkg::CHAN_OFS, 32'h9);
        rdc(acq_pkg::STAT_OFS, 32'h1);
        rdc(8'h20, 32'h0);
        for (int m = 0; m < 6; m++)
        begin
            wb(1'b1, acq_pkg::CTRL_OFS, m);
            rdc(acq_pkg::CTRL_OFS, m);
        end
        wb(1'b1, acq_pkg::CHAN_OFS, 32'h0);
        rdc(acq_pkg::CHAN_OFS, 32'h9);
        wb(1'b1, acq_pkg::CHAN_OFS, 32'h5);
        rdc(acq_pkg::CHAN_OFS, 32'h9);
        wb(1'b1, acq_pkg::CHAN_OFS, 32'h4);
        chk({28'h0, adc_bipolar_o, adc_gain_o}, 32'h4);
        wb(1'b1, acq_pkg::CHAN_OFS, 32'h8);
        rdc(acq_pkg::CHAN_OFS, 32'h8);
        // Single value: one result per software trigger
        wb(1'b1, acq_pkg::CTRL_OFS, 32'h0);
        repeat (2)
        begin
            wb(1'b1, acq_pkg::CMD_OFS, 32'h4);
            do wb(1'b0, acq_pkg::STAT_OFS, 32'h0); while (rd[0] !== 1'b0);
            drain();
            chk(got, 1);
        end
        // Internal pacer: 20 ticks of 10 MHz is 40 clocks per sample
        wb(1'b1, acq_pkg::PACE_OFS, 32'd20);
        wb(1'b1, acq_pkg::CTRL_OFS, 32'h1);
        wb(1'b1, acq_pkg::CMD_OFS, 32'h1);
        repeat (200) @(posedge mclk_i);
        wb(1'b1, acq_pkg::CMD_OFS, 32'h2);
        idle_wait();
        drain();
        chk(got >= 4 && got <= 6, 1);
        repeat (100) @(posedge mclk_i);
        rdc(acq_pkg::STAT_OFS, 32'h1);
        // External clock with one edge landing mid-conversion
        wb(1'b1, acq_pkg::CTRL_OFS, 32'h9);
        wb(1'b1, acq_pkg::CMD_OFS, 32'h1);
        sclk(2, 40);
        sclk(1, 7);
        sclk(1, 40);
        wb(1'b1, acq_pkg::CMD_OFS, 32'h2);
        drain();
        chk(got, 3);
        // Post-trigger, digital rising edge, N of 3
        wb(1'b1, acq_pkg::NCNT_OFS, 32'd3);
        wb(1'b1, acq_pkg::CTRL_OFS, 32'h9a);
        wb(1'b1, acq_pkg::CMD_OFS, 32'h1);
        sclk(2, 40);
        rdc(acq_pkg::STAT_OFS, 32'h7);
        dig_trg <= 1'b1;
        sclk(5, 40);
        dig_trg <= 1'b0;
        sclk(1, 4);
        dig_trg <= 1'b1;
        sclk(2, 40);
        drain();
        chk(got, 3);
        rdc(acq_pkg::STAT_OFS, 32'h1);
        // Delay-trigger, analog falling edge, M and N of 2
        wb(1'b1, acq_pkg::MCNT_OFS, 32'd2);
        wb(1'b1, acq_pkg::NCNT_OFS, 32'd2);
        wb(1'b1, acq_pkg::CTRL_OFS, 32'heb);
        wb(1'b1, acq_pkg::CMD_OFS, 32'h1);
        analog_threshold_trigger_pin <= 1'b0;
        sclk(3, 40);
        drain();
        chk(got, 1);
        sclk(2, 40);
        drain();
        chk(got, 1);
        rdc(acq_pkg::STAT_OFS, 32'h1);
        // Software trigger, stopped before N
        wb(1'b1, acq_pkg::NCNT_OFS, 32'd10);
        wb(1'b1, acq_pkg::CTRL_OFS, 32'h8a);
        wb(1'b1, acq_pkg::CMD_OFS, 32'h1);
        wb(1'b1, acq_pkg::CMD_OFS, 32'h4);
        sclk(2, 40);
        wb(1'b1, acq_pkg::CMD_OFS, 32'h2);
        sclk(2, 40);
        drain();
        chk(got, 2);
        rdc(acq_pkg::STAT_OFS, 32'h1);
        wrap_up();
    end
endmodule : tb
bind acq_seq acq_seq_assertions u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .adc_start_o(adc_start_o),
    .adc_done_i(adc_done_i), .adc_bipolar_o(adc_bipolar_o), .adc_gain_o(adc_gain_o));
`default_nettype wire
